// ### lrb_defines.svh
// Register offsets, field positions, reset values and codes for the refresh and blink timer
`ifndef LRB_DEFINES_SVH
`define LRB_DEFINES_SVH
`define LRB_ADDR_BLINK_MASK 8'h9E
`define LRB_ADDR_TOGGLE_RATE 8'h9F
`define LRB_ADDR_CONFIG 8'hA5
`define LRB_ADDR_PRESC_LOW 8'hA9
`define LRB_ADDR_PRESC_HIGH 8'hAA
`define LRB_RESET_BYTE 8'h00
`define LRB_CFG_CMP_BIT 5
`define LRB_TOG_CODE_MIN 4'h2
`define LRB_TOG_CODE_MAX 4'hD
`define LRB_PRESC_ZERO 10'h000
`define LRB_PRESC_ONE 10'h001
`define LRB_PH_ZERO 2'h0
`define LRB_PH_LAST 2'h3
`define LRB_MUX_ONE 2'h1
`define LRB_MUX_ZERO 2'h0
`define LRB_TOG_ZERO 13'h0000
`define LRB_TOG_ONE 13'h0001
`define LRB_TOG_DIV_BASE 13'h0001
`define LRB_TOG_CODE_BIAS 4'h1
`define LRB_TOG_RESET 4'h0
`define LRB_TOG_CODE_MSB 3
`define LRB_TOG_SPARE_ZERO 4'h0
`define LRB_PRESC_LOW_MSB 7
`define LRB_PRESC_HIGH_LSB 8
`define LRB_PRESC_MSB 9
`define LRB_PRESC_HIGH_FIELD_MSB 1
`define LRB_PRESC_SPARE_ZERO 6'h00
`define LRB_PH_ONE 2'h1
`define LRB_PAIR_W 2
`define LRB_PAIR_OFF 2'h0
`define LRB_COMMON_COUNT 4
`endif

// ### lrb_pkg.sv
// Types shared by the refresh and blink timer
package lrb_pkg;
    typedef logic [7:0] lrb_byte_t;
    typedef logic [1:0] lrb_mux_t;
endpackage

// ### lrb_top.sv
// Refresh prescaler, blink toggle divider and their special function registers
//
// Contract
// - Refresh timing runs from display clock enable
// - Refresh = clk / (4*mux*(prescaler+1))
// - Prescaler high bits 7:2 read zero
// - Masked segments toggle automatically, others steady
// - Mask bits align with first segment data
// - Blinkable count limited by multiplex mode
// - Toggle = refresh*mux*2 / divider
// - Divider code 2..13 gives 2..4096
// - Toggle register bits 7:4 read zero
// - Config bit 5 disables supply comparator
`timescale 1ns/1ps
`include "lrb_defines.svh"
module lrb_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Display clock tick from the clock divider, one cycle wide
    input wire logic disp_clk_tick,
    // Multiplex mode: 0 static, 1 two-mux, 2 three-mux, 3 four-mux
    input wire lrb_pkg::lrb_mux_t mux_mode,
    // Segment data of the first two segment pins
    input wire lrb_pkg::lrb_byte_t first_segment_data_register,
    // Special function register port
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire lrb_pkg::lrb_byte_t sfr_addr,
    input wire lrb_pkg::lrb_byte_t sfr_wdata,
    output lrb_pkg::lrb_byte_t sfr_rdata,
    // Timing, segment and comparator outputs
    output logic refresh_tick,
    output logic toggle_tick,
    output logic blink_phase,
    output lrb_pkg::lrb_byte_t segment_out,
    output logic supply_comparator_disable
);
    import lrb_pkg::*;

    // Stored register fields; spare bits have no storage at all
    lrb_byte_t blink_mask_q;
    logic [3:0] toggle_divider_code_q;
    logic cmp_dis_q;
    logic [9:0] refresh_prescaler_value_q;
    // Frame timing counters
    logic [9:0] presc_cnt_q;
    logic [1:0] phase_cnt_q;
    lrb_mux_t mux_cnt_q;
    logic [12:0] tog_cnt_q;
    logic [12:0] tog_div;
    logic frame_step;
    logic mux_wrap;
    // Read path and segment path
    lrb_byte_t rdata_d;
    wire lrb_byte_t seg_d;
    wire lrb_byte_t seg_next;

    // Register writes; spare bits are simply not stored, so they cannot leak
    // back on a read. No byte pairing: each prescaler byte lands on its own
    // write, so a frame may run once with a half-updated prescaler.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            blink_mask_q <= `LRB_RESET_BYTE;
            toggle_divider_code_q <= `LRB_TOG_RESET;
            cmp_dis_q <= 1'b0;
            refresh_prescaler_value_q <= `LRB_PRESC_ZERO;
        end else if (sfr_wr) begin
            if (sfr_addr == `LRB_ADDR_BLINK_MASK) begin
                blink_mask_q <= sfr_wdata;
            end else if (sfr_addr == `LRB_ADDR_TOGGLE_RATE) begin
                toggle_divider_code_q <= sfr_wdata[`LRB_TOG_CODE_MSB:0];
            end else if (sfr_addr == `LRB_ADDR_CONFIG) begin
                cmp_dis_q <= sfr_wdata[`LRB_CFG_CMP_BIT];
            end else if (sfr_addr == `LRB_ADDR_PRESC_LOW) begin
                refresh_prescaler_value_q[`LRB_PRESC_LOW_MSB:0] <= sfr_wdata;
            end else if (sfr_addr == `LRB_ADDR_PRESC_HIGH) begin
                refresh_prescaler_value_q[`LRB_PRESC_MSB:`LRB_PRESC_HIGH_LSB] <=
                    sfr_wdata[`LRB_PRESC_HIGH_FIELD_MSB:0];
            end
        end
    end

    // Read mux; unmapped addresses read zero. Spare bits are tied low here
    // rather than stored, so they read zero whatever software wrote.
    always_comb begin
        rdata_d = `LRB_RESET_BYTE;
        if (sfr_addr == `LRB_ADDR_BLINK_MASK) begin
            rdata_d = blink_mask_q;
        end else if (sfr_addr == `LRB_ADDR_TOGGLE_RATE) begin
            rdata_d = {`LRB_TOG_SPARE_ZERO, toggle_divider_code_q};
        end else if (sfr_addr == `LRB_ADDR_CONFIG) begin
            rdata_d[`LRB_CFG_CMP_BIT] = cmp_dis_q;
        end else if (sfr_addr == `LRB_ADDR_PRESC_LOW) begin
            rdata_d = refresh_prescaler_value_q[`LRB_PRESC_LOW_MSB:0];
        end else if (sfr_addr == `LRB_ADDR_PRESC_HIGH) begin
            rdata_d = {`LRB_PRESC_SPARE_ZERO,
                       refresh_prescaler_value_q[`LRB_PRESC_MSB:`LRB_PRESC_HIGH_LSB]};
        end
    end

    // Registered read data, valid the cycle after sfr_rd
    // It holds until the next read, so a slow fetch can still pick it up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= `LRB_RESET_BYTE;
        end else if (sfr_rd) begin
            sfr_rdata <= rdata_d;
        end
    end

    // Comparator disable drives the analog block from a flop that copies its register one cycle later,
    // so a decode glitch on the bus never reaches the analog side
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            supply_comparator_disable <= 1'b0;
        end else begin
            supply_comparator_disable <= cmp_dis_q;
        end
    end

    // Prescaler: one step every prescaler+1 display clocks
    // Display ticks come from this same clock, so no synchroniser is needed
    assign frame_step = disp_clk_tick && (presc_cnt_q == refresh_prescaler_value_q);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            presc_cnt_q <= `LRB_PRESC_ZERO;
        end else if (disp_clk_tick) begin
            if (presc_cnt_q >= refresh_prescaler_value_q) begin
                presc_cnt_q <= `LRB_PRESC_ZERO; // Wrap also covers a shrunk prescaler
            end else begin
                presc_cnt_q <= presc_cnt_q + `LRB_PRESC_ONE;
            end
        end
    end

    // Four phases per common, mux_mode+1 commons per frame
    // A mode change lands at the next common boundary; a common count already
    // past the new mode wraps there instead of running on to the top.
    assign mux_wrap = frame_step && (phase_cnt_q == `LRB_PH_LAST) && (mux_cnt_q >= mux_mode);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_cnt_q <= `LRB_PH_ZERO;
            mux_cnt_q <= `LRB_MUX_ZERO;
        end else if (frame_step) begin
            phase_cnt_q <= phase_cnt_q + `LRB_PH_ONE;
            if (phase_cnt_q == `LRB_PH_LAST) begin
                mux_cnt_q <= (mux_cnt_q >= mux_mode) ? `LRB_MUX_ZERO
                                                      : mux_cnt_q + `LRB_MUX_ONE;
            end
        end
    end

    // Refresh tick marks the end of each frame
    // Registered so the pulse is one clean cycle wide
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            refresh_tick <= 1'b0;
        end else begin
            refresh_tick <= mux_wrap;
        end
    end

    // Divider 2^(code-1); the toggle counter runs at refresh*mux*2, i.e. twice per frame
    // per common, so it counts half-common steps (two prescaler phases).
    // A code change mid-count wraps a count already past the new end at its next step,
    // so the first blink period after a change may be short. Codes outside
    // 2..13 are left to software to avoid; here they simply stop the count.
    assign tog_div = `LRB_TOG_DIV_BASE << (toggle_divider_code_q - `LRB_TOG_CODE_BIAS);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tog_cnt_q <= `LRB_TOG_ZERO;
            toggle_tick <= 1'b0;
        end else begin
            toggle_tick <= 1'b0;
            // Reserved codes hold the phase still rather than produce a guessed rate
            if (frame_step && phase_cnt_q[0] &&
                toggle_divider_code_q >= `LRB_TOG_CODE_MIN &&
                toggle_divider_code_q <= `LRB_TOG_CODE_MAX) begin
                if (tog_cnt_q >= tog_div - `LRB_TOG_ONE) begin
                    tog_cnt_q <= `LRB_TOG_ZERO;
                    toggle_tick <= 1'b1;
                end else begin
                    tog_cnt_q <= tog_cnt_q + `LRB_TOG_ONE;
                end
            end
        end
    end

    // Shared blink phase, starts visible
    // Reset leaves it visible so a set mask never blanks a segment at power-up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            blink_phase <= 1'b1;
        end else if (toggle_tick) begin
            blink_phase <= ~blink_phase;
        end
    end

    // Per common pair: masked segments blank in the off phase, then the pair is
    // forced off when its common is unused. Only segments of active commons
    // exist, which is what bounds how many segments can blink per mux mode.
    for (genvar k = 0; k < `LRB_COMMON_COUNT; k++) begin : g_common
        assign seg_d[`LRB_PAIR_W*k +: `LRB_PAIR_W] =
            first_segment_data_register[`LRB_PAIR_W*k +: `LRB_PAIR_W] &
            ~(blink_mask_q[`LRB_PAIR_W*k +: `LRB_PAIR_W] & {`LRB_PAIR_W{~blink_phase}});
        assign seg_next[`LRB_PAIR_W*k +: `LRB_PAIR_W] = (k <= mux_mode) ?
            seg_d[`LRB_PAIR_W*k +: `LRB_PAIR_W] : `LRB_PAIR_OFF;
    end

    // Segment pins come straight from flops, one cycle after the data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            segment_out <= `LRB_RESET_BYTE;
        end else begin
            segment_out <= seg_next;
        end
    end
endmodule // lrb_top

// ### lrb_chk.sv
// Port assertions for the refresh and blink timer
`timescale 1ns/1ps
module lrb_chk (
    // Clock, reset and inputs
    input wire logic clk,
    input wire logic rst,
    input wire lrb_pkg::lrb_mux_t mux_mode,
    input wire lrb_pkg::lrb_byte_t first_segment_data_register,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire lrb_pkg::lrb_byte_t sfr_addr,
    input wire lrb_pkg::lrb_byte_t sfr_wdata,
    // Outputs
    input wire lrb_pkg::lrb_byte_t sfr_rdata,
    input wire logic toggle_tick,
    input wire logic blink_phase,
    input wire lrb_pkg::lrb_byte_t segment_out,
    input wire logic supply_comparator_disable
);
    import lrb_pkg::*;
    // One clock domain; reset masks every check
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_high_spare: assert property ($past(sfr_rd) && $past(sfr_addr) == 8'hAA
        |-> sfr_rdata[7:2] == 6'h00) else $error("prescaler spare bits set");
    a_tog_spare: assert property ($past(sfr_rd) && $past(sfr_addr) == 8'h9F
        |-> sfr_rdata[7:4] == 4'h0) else $error("toggle spare bits set");
    a_cfg_spare: assert property ($past(sfr_rd) && $past(sfr_addr) == 8'hA5
        |-> (sfr_rdata & 8'hDF) == 8'h00) else $error("config spare bits set");
    a_cmp_follow: assert property (sfr_wr && sfr_addr == 8'hA5
        |-> ##2 supply_comparator_disable == $past(sfr_wdata[5], 2)) else $error("cmp bit");
    // A segment is never lit unless its data bit was set
    a_seg_data: assert property ((segment_out & ~$past(first_segment_data_register)) == 8'h00)
        else $error("segment lit without data");
    a_mux_blank: assert property ((segment_out >> (2 * $past(mux_mode) + 2)) == 8'h00)
        else $error("unused common pair driven");
    a_phase_cause: assert property ($changed(blink_phase) |-> toggle_tick || $past(toggle_tick))
        else $error("phase moved without toggle");
    a_tick_pulse: assert property (toggle_tick |=> !toggle_tick)
        else $error("toggle tick too long");
endmodule // lrb_chk
bind lrb_top lrb_chk u_chk (.clk(clk), .rst(rst), .mux_mode(mux_mode),
    .first_segment_data_register(first_segment_data_register), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .toggle_tick(toggle_tick), .blink_phase(blink_phase), .segment_out(segment_out),
    .supply_comparator_disable(supply_comparator_disable));

// ### tb_lrb_top.sv
// Self-checking bench for the refresh and blink timer
`timescale 1ns/1ps
module tb_lrb_top;
    import lrb_pkg::*;
    logic clk = 1'b0, rst = 1'b1, disp_clk_tick = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
    lrb_mux_t mux_mode = 2'h3;
    lrb_byte_t data = 8'hB7, sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, segment_out;
    logic refresh_tick, toggle_tick, blink_phase, cmp_off, ph;
    int mismatches = 0, comparisons = 0, cycles = 0, n;
    lrb_byte_t addrs [6] = '{8'h9E, 8'h9F, 8'hA5, 8'hA9, 8'hAA, 8'h55};
    // Write values keep reserved config bits clear and the divider code legal
    lrb_byte_t wdat [6] = '{8'hFF, 8'hFD, 8'h20, 8'hFF, 8'hFF, 8'hFF};
    lrb_byte_t full [6] = '{8'hFF, 8'h0D, 8'h20, 8'hFF, 8'h03, 8'h00};
    lrb_top dut_u (.clk(clk), .rst(rst), .disp_clk_tick(disp_clk_tick), .mux_mode(mux_mode),
        .first_segment_data_register(data), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .refresh_tick(refresh_tick), .toggle_tick(toggle_tick), .blink_phase(blink_phase),
        .segment_out(segment_out), .supply_comparator_disable(cmp_off));
    always #2 clk = ~clk;
    // Display ticks every second cycle, so timing must count ticks and not clk edges
    always @(negedge clk) disp_clk_tick <= ~disp_clk_tick;
    // Longest test is the divide-by-4096 toggle, about 65000 cycles in all
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input lrb_byte_t a, input lrb_byte_t d);
        @(negedge clk);
        {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rdchk(input lrb_byte_t a, input lrb_byte_t e);
        @(negedge clk);
        {sfr_rd, sfr_addr} = {1'b1, a};
        @(negedge clk);
        sfr_rd = 1'b0;
        chk(16'(sfr_rdata), 16'(e));
    endtask
    // Cycles from one tick to the next; the first tick only aligns the count
    task automatic gap(input bit tog, output int c);
        c = 1;
        while ((tog ? toggle_tick : refresh_tick) !== 1'b1) @(negedge clk);
        @(negedge clk);
        while ((tog ? toggle_tick : refresh_tick) !== 1'b1) begin
            @(negedge clk);
            c++;
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        chk(16'(blink_phase), 16'h0001);
        chk(16'(segment_out), 16'h0000);
        foreach (addrs[i]) rdchk(addrs[i], 8'h00);
        foreach (addrs[i]) wr(addrs[i], wdat[i]);
        foreach (addrs[i]) rdchk(addrs[i], full[i]);
        chk(16'(cmp_off), 16'h0001);
        wr(8'hA5, 8'h00);
        @(negedge clk);
        chk(16'(cmp_off), 16'h0000);
        $display("register test done");
        wr(8'hA9, 8'h02);
        wr(8'hAA, 8'h00);
        for (int m = 0; m < 4; m++) begin
            mux_mode = m[1:0];
            gap(1'b0, n);
            gap(1'b0, n);
            chk(16'(n), 16'(24 * (m + 1)));
        end
        $display("refresh test done");
        wr(8'hA9, 8'h00);
        for (int c = 2; c <= 13; c++) begin
            wr(8'h9F, 8'(c));
            gap(1'b1, n);
            chk(16'(n), 16'(2 ** (c + 1)));
            ph = blink_phase;
            @(negedge clk);
            chk(16'(blink_phase), 16'(!ph));
        end
        $display("toggle test done");
        wr(8'h9F, 8'h02);
        wr(8'h9E, 8'h0F);
        for (int m = 0; m < 4; m++) begin
            mux_mode = m[1:0];
            repeat (2) @(negedge clk);
            repeat (12) begin
                ph = blink_phase;
                @(negedge clk);
                chk(16'(segment_out), 16'(data & ~(8'h0F & {8{~ph}}) & 8'((16'h1 << (2 * m + 2)) - 1)));
            end
        end
        $display("blink test done");
        report_and_stop();
    end
endmodule // tb_lrb_top
